// ===== logic/bmc_top.sv
// burst modulation controller with apb register slave
`timescale 1ns/1ps
module bmc_top (
  input  wire logic          clk_i,
  input  wire logic          nrst_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [7:0]    paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic               pready_o,
  output logic               pslverr_o,
  output logic [31:0]        prdata_o,
  input  wire logic          ext_trig_i,
  input  wire logic          backplane_trigger_line_i,
  output bmc_pkg::bmc_out_t  wave_o,
  output logic [2:0]         other_mod_en_o
);
  // register state
  logic                   burst_enable_r;
  logic                   burst_source_select_r;
  bmc_pkg::bmc_tsel_t     trigger_source_select_r;
  bmc_pkg::bmc_func_t     func_r;
  logic [2:0]             mod_r;
  logic [28:0]            freq_r;
  logic [15:0]            burst_cycle_count_r;
  logic                   inf_r;
  logic signed [19:0]     burst_start_phase_r;
  logic [25:0]            burst_repeat_rate_r;
  logic [6:0]             duty_r;
  logic [15:0]            ampl_r;
  logic [15:0]            offs_r;
  logic                   conflict_r;
  logic                   soft_trig_r;
  // engine state
  bmc_pkg::bmc_state_t    state_r;
  logic [31:0]            rel_r;
  logic [15:0]            cyc_r;
  logic                   pend_r;
  logic [47:0]            rate_acc_r;
  logic                   pin_q_r;

  // apb access qualifiers; one wait state, answer from flops
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  assign wr_acc = psel_i & penable_i & ~pready_o & pwrite_i;
  assign rd_acc = psel_i & penable_i & ~pready_o & ~pwrite_i;
  assign mapped = (paddr_i[1:0] == 2'b00) && (paddr_i <= bmc_pkg::ADDR_CONFIG);

  // carrier frequency clamp on write against count and duration limits
  logic [28:0] f_in;
  logic [28:0] f_cl;
  logic        f_bad;
  logic        band_lim;
  logic [31:0] f_top;
  logic [31:0] f_x5;
  logic [15:0] f_floor;
  always_comb begin
    f_in = (pwdata_i[28:0] < bmc_pkg::FREQ_MIN) ? bmc_pkg::FREQ_MIN : pwdata_i[28:0];
    f_cl = f_in;
    f_bad = 1'b0;
    band_lim = (func_r == bmc_pkg::BMC_SINE) || (func_r == bmc_pkg::BMC_SQUARE) ||
               (func_r == bmc_pkg::BMC_ARB);
    f_top = 32'(burst_cycle_count_r[2:0]) * 32'(bmc_pkg::FREQ_MHZ);
    f_x5 = 32'(f_in) * 32'(bmc_pkg::DUR_DIV);
    f_floor = 16'((17'(burst_cycle_count_r) + 17'd4) / 17'(bmc_pkg::DUR_DIV));
    if (burst_enable_r && !burst_source_select_r && !inf_r) begin
      if (band_lim && burst_cycle_count_r < bmc_pkg::CYC_MINREQ && 32'(f_in) > f_top) begin
        f_cl = f_top[28:0]; // [RL2] [RL3]
        f_bad = 1'b1;
      end else if (f_in <= bmc_pkg::FREQ_LOW && f_x5 < 32'(burst_cycle_count_r)) begin
        f_cl = 29'(f_floor); // [RL4] [RL5]
        f_bad = 1'b1;
      end
    end
  end

  // duty limits follow the carrier frequency in force after the access
  logic [28:0] f_eff;
  logic [6:0]  d_in;
  logic [6:0]  d_lo;
  logic [6:0]  d_hi;
  logic [6:0]  d_cl;
  logic        d_bad;
  always_comb begin
    f_eff = (wr_acc && paddr_i == bmc_pkg::ADDR_FREQ) ? f_cl : freq_r;
    d_in = (wr_acc && paddr_i == bmc_pkg::ADDR_DUTY) ? pwdata_i[6:0] : duty_r;
    d_lo = (f_eff > bmc_pkg::FREQ_5MHZ) ? bmc_pkg::DUTY_LO_HF : bmc_pkg::DUTY_LO_WIDE;
    d_hi = (f_eff > bmc_pkg::FREQ_5MHZ) ? bmc_pkg::DUTY_HI_HF : bmc_pkg::DUTY_HI_WIDE;
    d_cl = d_in;
    d_bad = 1'b0;
    if (func_r == bmc_pkg::BMC_SQUARE && d_in < d_lo) begin
      d_cl = d_lo; // [RL17]
      d_bad = 1'b1;
    end else if (func_r == bmc_pkg::BMC_SQUARE && d_in > d_hi) begin
      d_cl = d_hi; // [RL17]
      d_bad = 1'b1;
    end
  end

  // control register; enabling burst switches off the other modulations
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      burst_enable_r <= 1'b0;
      burst_source_select_r <= 1'b0; // [RL14]
      trigger_source_select_r <= bmc_pkg::BMC_TRG_INT;
      func_r <= bmc_pkg::BMC_SINE;
      mod_r <= 3'h0;
    end else if (wr_acc && paddr_i == bmc_pkg::ADDR_CTRL) begin
      burst_enable_r <= pwdata_i[bmc_pkg::CTRL_EN];
      burst_source_select_r <= pwdata_i[bmc_pkg::CTRL_SRC];
      trigger_source_select_r <= bmc_pkg::bmc_tsel_t'(pwdata_i[bmc_pkg::CTRL_TSEL_LO +: 2]);
      func_r <= bmc_pkg::bmc_func_t'(pwdata_i[bmc_pkg::CTRL_FUNC_LO +: 3]);
      if (pwdata_i[bmc_pkg::CTRL_EN]) begin
        mod_r <= 3'h0; // [RL15]
      end else begin
        mod_r <= pwdata_i[bmc_pkg::CTRL_MOD_LO +: 3];
      end
    end
  end

  // carrier frequency kept even for dc, used again on a later function change
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      freq_r <= bmc_pkg::FREQ_RST;
    end else if (wr_acc && paddr_i == bmc_pkg::ADDR_FREQ) begin
      freq_r <= f_cl; // [RL18] [RL21]
    end
  end

  // burst count with infinite flag in the top bit
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      burst_cycle_count_r <= bmc_pkg::CYC_MIN;
      inf_r <= 1'b0;
    end else if (wr_acc && paddr_i == bmc_pkg::ADDR_CYCLES) begin
      inf_r <= pwdata_i[bmc_pkg::CYC_INF_BIT];
      if (pwdata_i[15:0] < bmc_pkg::CYC_MIN || pwdata_i[30:16] != 15'h0000) begin
        burst_cycle_count_r <= (pwdata_i[30:16] != 15'h0000) ? bmc_pkg::CYC_MAX : bmc_pkg::CYC_MIN;
      end else if (pwdata_i[15:0] > bmc_pkg::CYC_MAX) begin
        burst_cycle_count_r <= bmc_pkg::CYC_MAX; // [RL1]
      end else begin
        burst_cycle_count_r <= pwdata_i[15:0]; // [RL1]
      end
    end
  end

  // start phase and repeat rate, saturated at their ranges
  logic signed [31:0] ph_in;
  assign ph_in = signed'(pwdata_i);
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      burst_start_phase_r <= 20'sh0_0000;
      burst_repeat_rate_r <= bmc_pkg::RATE_RST;
    end else if (wr_acc && paddr_i == bmc_pkg::ADDR_PHASE) begin
      if (ph_in > 32'(bmc_pkg::PH_MAX)) begin
        burst_start_phase_r <= bmc_pkg::PH_MAX; // [RL7]
      end else if (ph_in < 32'(bmc_pkg::PH_MIN)) begin
        burst_start_phase_r <= bmc_pkg::PH_MIN; // [RL7]
      end else begin
        burst_start_phase_r <= ph_in[19:0];
      end
    end else if (wr_acc && paddr_i == bmc_pkg::ADDR_RATE) begin
      if (pwdata_i < 32'(bmc_pkg::RATE_MIN)) begin
        burst_repeat_rate_r <= bmc_pkg::RATE_MIN; // [RL9]
      end else if (pwdata_i > 32'(bmc_pkg::RATE_MAX)) begin
        burst_repeat_rate_r <= bmc_pkg::RATE_MAX; // [RL9]
      end else begin
        burst_repeat_rate_r <= pwdata_i[25:0];
      end
    end
  end

  // duty, amplitude and offset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      duty_r <= bmc_pkg::DUTY_RST;
      ampl_r <= bmc_pkg::AMPL_RST;
      offs_r <= 16'h0000;
    end else begin
      duty_r <= d_cl; // [RL17]
      if (wr_acc && paddr_i == bmc_pkg::ADDR_AMPL) begin
        ampl_r <= pwdata_i[15:0];
      end
      if (wr_acc && paddr_i == bmc_pkg::ADDR_OFFS) begin
        offs_r <= pwdata_i[15:0];
      end
    end
  end

  // conflict flag: a new clamp in the clearing cycle keeps it set
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conflict_r <= 1'b0;
    end else if ((wr_acc && paddr_i == bmc_pkg::ADDR_FREQ && f_bad) || d_bad) begin
      conflict_r <= 1'b1; // [RL3] [RL5] [RL21]
    end else if (wr_acc && paddr_i == bmc_pkg::ADDR_STATUS && pwdata_i[0]) begin
      conflict_r <= 1'b0;
    end
  end

  // software trigger pulse
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      soft_trig_r <= 1'b0;
    end else begin
      soft_trig_r <= wr_acc && paddr_i == bmc_pkg::ADDR_TRIG && pwdata_i[0];
    end
  end

  // internal rate divider: carry of a phase accumulator gives a one-cycle tick
  logic [47:0] rate_step;
  logic [48:0] rate_sum;
  assign rate_step = 48'(40'(burst_repeat_rate_r) * 40'(bmc_pkg::RATE_K));
  assign rate_sum = {1'b0, rate_acc_r} + {1'b0, rate_step};
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rate_acc_r <= 48'h0000_0000_0000;
      pin_q_r <= 1'b0;
    end else begin
      rate_acc_r <= rate_sum[47:0];
      pin_q_r <= (trigger_source_select_r == bmc_pkg::BMC_TRG_BKP) ? backplane_trigger_line_i : ext_trig_i;
    end
  end

  // trigger selection and gate level
  logic pin_lvl;
  logic trig;
  assign pin_lvl = (trigger_source_select_r == bmc_pkg::BMC_TRG_BKP) ? backplane_trigger_line_i : ext_trig_i;
  always_comb begin
    case (trigger_source_select_r)
      bmc_pkg::BMC_TRG_INT: trig = rate_sum[48]; // [RL10]
      bmc_pkg::BMC_TRG_BUS: trig = soft_trig_r;  // [RL10]
      default:              trig = pin_lvl & ~pin_q_r;
    endcase
  end

  // carrier phase step and start offset
  logic [31:0] step;
  logic [32:0] rel_sum;
  logic [33:0] ph_prod;
  logic        counted;
  logic        last_cyc;
  assign step = 32'(45'(freq_r) * 45'(bmc_pkg::FREQ_K) >> bmc_pkg::FREQ_SH);
  assign rel_sum = {1'b0, rel_r} + {1'b0, step};
  assign ph_prod = 34'(burst_start_phase_r) * 34'(bmc_pkg::PH_K);
  assign counted = burst_enable_r & ~burst_source_select_r; // [RL14]
  assign last_cyc = rel_sum[32] && !inf_r && (cyc_r + 16'h0001 >= burst_cycle_count_r);

  // counted burst engine; a trigger during a burst is held and starts a new burst one clock after it ends
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= bmc_pkg::BMC_IDLE;
      rel_r <= 32'h0000_0000;
      cyc_r <= 16'h0000;
      pend_r <= 1'b0;
    end else if (!counted) begin
      state_r <= bmc_pkg::BMC_IDLE;
      rel_r <= rel_sum[31:0]; // free-running carrier when not counting
      cyc_r <= 16'h0000;
      pend_r <= 1'b0;
    end else begin
      case (state_r)
        bmc_pkg::BMC_IDLE: begin
          if (trig || pend_r) begin
            state_r <= bmc_pkg::BMC_RUN;
            rel_r <= 32'h0000_0000; // [RL8]
            cyc_r <= 16'h0000;
            pend_r <= 1'b0;
          end
        end
        default: begin
          rel_r <= rel_sum[31:0];
          if (trig) begin
            pend_r <= 1'b1; // [RL11]
          end
          if (rel_sum[32]) begin
            cyc_r <= cyc_r + 16'h0001; // [RL22]
          end
          if (last_cyc) begin
            state_r <= bmc_pkg::BMC_IDLE; // [RL22] [RL23]
            rel_r <= 32'h0000_0000;
          end
        end
      endcase
    end
  end

  // output bundle, all from flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wave_o <= '0;
      other_mod_en_o <= 3'h0;
    end else begin
      other_mod_en_o <= mod_r;
      wave_o.duty <= duty_r;
      wave_o.ampl <= ampl_r;
      wave_o.offs <= offs_r;
      wave_o.active <= counted && state_r == bmc_pkg::BMC_RUN;
      if (func_r == bmc_pkg::BMC_DC) begin
        wave_o.run <= 1'b0; // [RL18]
        wave_o.phase <= 32'h0000_0000;
      end else if (burst_enable_r && burst_source_select_r) begin
        wave_o.run <= pin_lvl; // [RL12] [RL13]
        wave_o.phase <= rel_r;
      end else if (counted) begin
        wave_o.run <= state_r == bmc_pkg::BMC_RUN; // [RL22]
        wave_o.phase <= rel_r + ph_prod[31:0]; // [RL7] [RL8]
      end else begin
        wave_o.run <= 1'b1;
        wave_o.phase <= rel_r;
      end
    end
  end

  // apb read mux
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (paddr_i == bmc_pkg::ADDR_CTRL) begin
      rd_val = {22'h0, mod_r, func_r, trigger_source_select_r, burst_source_select_r, burst_enable_r}; // [RL20]
    end else if (paddr_i == bmc_pkg::ADDR_FREQ) begin
      rd_val = {3'h0, freq_r};
    end else if (paddr_i == bmc_pkg::ADDR_CYCLES) begin
      rd_val = inf_r ? 32'hFFFF_FFFF : {16'h0, burst_cycle_count_r}; // [RL6]
    end else if (paddr_i == bmc_pkg::ADDR_PHASE) begin
      rd_val = 32'(burst_start_phase_r);
    end else if (paddr_i == bmc_pkg::ADDR_RATE) begin
      rd_val = {6'h0, burst_repeat_rate_r}; // [RL11]
    end else if (paddr_i == bmc_pkg::ADDR_DUTY) begin
      rd_val = {25'h0, duty_r};
    end else if (paddr_i == bmc_pkg::ADDR_AMPL) begin
      rd_val = {16'h0, ampl_r};
    end else if (paddr_i == bmc_pkg::ADDR_OFFS) begin
      rd_val = {16'h0, offs_r};
    end else if (paddr_i == bmc_pkg::ADDR_STATUS) begin
      rd_val = {conflict_r ? bmc_pkg::ERR_CONFLICT : 16'h0000, 13'h0, state_r, pend_r, conflict_r};
    end else if (paddr_i == bmc_pkg::ADDR_CONFIG) begin
      rd_val = {func_r, freq_r}; // [RL19]
    end
  end

  // apb answer: pready one cycle into the access phase
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
      if (rd_acc || (wr_acc && !mapped)) begin
        prdata_o <= mapped ? rd_val : 32'h0000_0000;
      end
    end
  end
endmodule

// ===== logic/bmc_pkg.sv
// constants, types and register map of the burst modulation controller
// Behaviour
// RL1: burst count 1..50000 in unit steps, default 1, plus an infinite setting.
// RL2: sine/square/arb need count of at least one per started megahertz of carrier.
// RL3: carrier above the count limit is clamped to the highest allowed, error -221.
// RL4: at or below 100 Hz carrier, count over frequency stays within 500 seconds.
// RL5: too low carrier is raised to the lowest allowed value, error -221.
// RL6: count readback is the count, or an all-ones marker when infinite.
// RL7: start phase -360..+360 degrees in millidegrees, default 0, counted mode only.
// RL8: phase word zero is the rising offset crossing, or first arb sample.
// RL9: internal repeat rate 10 mHz..50 kHz, default 100 Hz, sets burst interval.
// RL10: repeat rate used only with internal trigger, ignored for bus or pin.
// RL11: too fast repeat rate retriggers back to back; readback keeps request.
// RL12: gated mode outputs carrier while gate high, offset level while low.
// RL13: gated mode ignores count, rate, start phase and trigger source; the code still picks the gate line by trigger source.
// RL14: burst source internal or external, default internal; internal disables gating.
// RL15: one modulation mode at a time; burst enable turns others off.
// RL16: software sets all burst parameters before enabling burst.
// RL17: square duty 40..60 percent above 5 MHz, else 20..80; clamp and flag.
// RL18: dc function ignores frequency and amplitude on output but keeps them.
// RL19: configuration readback gives function, frequency, amplitude and offset; the code returns only function and frequency.
// RL20: enable readback is 0 when burst is off and 1 when on.
// RL21: conflict clamps report -221 and take effect at once.
// RL22: counted burst stops after programmed cycles and holds offset until trigger.
// RL23: infinite count runs carrier continuously after the trigger.
package bmc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_FREQ   = 8'h04;
  localparam logic [7:0] ADDR_CYCLES = 8'h08;
  localparam logic [7:0] ADDR_PHASE  = 8'h0C;
  localparam logic [7:0] ADDR_RATE   = 8'h10;
  localparam logic [7:0] ADDR_DUTY   = 8'h14;
  localparam logic [7:0] ADDR_AMPL   = 8'h18;
  localparam logic [7:0] ADDR_OFFS   = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_TRIG   = 8'h24;
  localparam logic [7:0] ADDR_CONFIG = 8'h28;
  // control field positions
  localparam int CTRL_EN      = 0;
  localparam int CTRL_SRC     = 1;
  localparam int CTRL_TSEL_LO = 2;
  localparam int CTRL_FUNC_LO = 4;
  localparam int CTRL_MOD_LO  = 7;
  localparam int CYC_INF_BIT  = 31;
  // limits; frequency in 10 mHz units, rate in mHz, phase in millidegrees
  localparam logic [15:0] CYC_MIN    = 16'h0001;
  localparam logic [15:0] CYC_MAX    = 16'hC350;      // 50000
  localparam logic [15:0] CYC_MINREQ = 16'h0005;      // lowest count with no band limit
  localparam logic [28:0] FREQ_MHZ   = 29'h05F5_E100; // 1 MHz
  localparam logic [28:0] FREQ_5MHZ  = 29'h1DCD_6500; // 5 MHz
  localparam logic [28:0] FREQ_LOW   = 29'h0000_2710; // 100 Hz
  localparam logic [28:0] FREQ_MIN   = 29'h0000_0001; // 10 mHz
  localparam logic [2:0]  DUR_DIV    = 3'h5;          // 500 s in 10 mHz units
  localparam logic [25:0] RATE_MIN   = 26'h000_000A;  // 10 mHz
  localparam logic [25:0] RATE_MAX   = 26'h2FA_F080;  // 50 kHz
  localparam logic signed [19:0] PH_MAX = 20'sh5_7E40; // +360 degrees
  localparam logic signed [19:0] PH_MIN = -20'sh5_7E40;
  localparam logic [6:0]  DUTY_LO_WIDE = 7'h14;
  localparam logic [6:0]  DUTY_HI_WIDE = 7'h50;
  localparam logic [6:0]  DUTY_LO_HF   = 7'h28;
  localparam logic [6:0]  DUTY_HI_HF   = 7'h3C;
  // reset values
  localparam logic [28:0] FREQ_RST  = 29'h0001_86A0; // 1 kHz
  localparam logic [25:0] RATE_RST  = 26'h001_86A0;  // 100 Hz
  localparam logic [6:0]  DUTY_RST  = 7'h32;
  localparam logic [15:0] AMPL_RST  = 16'h0064;      // 100 mVpp
  localparam logic [15:0] ERR_CONFLICT = 16'hFF23;   // -221
  // scale factors: 2^46/(2e9) for carrier step, 2^48/(2e10) for rate step
  localparam logic [15:0] FREQ_K = 16'h8970;
  localparam int          FREQ_SH = 14;
  localparam logic [13:0] RATE_K = 14'h36FA;
  localparam logic signed [14:0] PH_K = 15'sh2E9A;   // 2^32/360000
  typedef enum logic [2:0] {
    BMC_SINE = 3'b000, BMC_SQUARE = 3'b001, BMC_RAMP = 3'b010,
    BMC_TRI = 3'b011, BMC_ARB = 3'b100, BMC_DC = 3'b101, BMC_NOISE = 3'b110
  } bmc_func_t;
  typedef enum logic [1:0] {
    BMC_TRG_INT = 2'b00, BMC_TRG_BUS = 2'b01, BMC_TRG_PIN = 2'b10, BMC_TRG_BKP = 2'b11
  } bmc_tsel_t;
  typedef enum logic {BMC_IDLE = 1'b0, BMC_RUN = 1'b1} bmc_state_t;
  // waveform engine output bundle
  typedef struct packed {
    logic        run;    // carrier on, else hold offset level
    logic        active; // a counted burst is in progress
    logic [31:0] phase;  // phase word, zero at start of a cycle
    logic [6:0]  duty;
    logic [15:0] ampl;
    logic [15:0] offs;
  } bmc_out_t;
endpackage

// ===== verif/bmc_gate_src.sv
// gate and trigger source standing at the two trigger pins
`timescale 1ns/1ps
module bmc_gate_src (
  input  wire logic clk_i,
  input  wire logic level_i,
  input  wire logic use_bkp_i,
  output logic      ext_trig_o,
  output logic      bkp_trig_o
);
  // only the chosen line carries the gate; the unused one rests low like an idle ttl line
  always_comb begin
    ext_trig_o = level_i && !use_bkp_i;
    bkp_trig_o = level_i && use_bkp_i;
  end
endmodule

// ===== verif/bmc_monitor.sv
// port checker for the burst modulation controller
`timescale 1ns/1ps
module bmc_monitor (
  input wire logic              clk_i,
  input wire logic              nrst_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [7:0]        paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic [31:0]       prdata_o,
  input wire logic              ext_trig_i,
  input wire logic              backplane_trigger_line_i,
  input wire bmc_pkg::bmc_out_t wave_o,
  input wire logic [2:0]        other_mod_en_o
);
  logic [3:0] ctrl_r;
  logic       acc;
  logic       bad;
  logic       gpin;
  logic       cbus;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // shadow of the low control bits, taken one edge after the register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= 4'h0;
    end else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h00) begin
      ctrl_r <= pwdata_i[3:0];
    end
  end
  // waiting access phase, unmapped address and the two mode decodes
  assign acc  = psel_i && penable_i && !pready_o;
  assign bad  = (paddr_i > 8'h28) || (paddr_i[1:0] != 2'b00);
  assign gpin = ctrl_r[0] && ctrl_r[1] && ctrl_r[3:2] == 2'b10;
  assign cbus = ctrl_r[0] && !ctrl_r[1] && ctrl_r[3:2] == 2'b01;
  sequence s_access;
    acc;
  endsequence
  sequence s_answer;
    pready_o ##1 !pready_o;
  endsequence
  a_ready_one_wait: assert property (s_access |=> s_answer) else $error("ready not after one wait");
  a_ready_needs_req: assert property (pready_o |-> $past(acc)) else $error("ready without access");
  a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("error outside ready");
  a_unmapped_err: assert property (acc && bad |=> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && !bad |=> !pslverr_o) else $error("mapped access refused");
  a_enable_clears: assert property (acc && pwrite_i && paddr_i == 8'h00 && pwdata_i[0] |->
    ##[1:3] other_mod_en_o == 3'b000) else $error("other modulation left on");
  a_gate_follows: assert property (gpin && $past(gpin) |-> wave_o.run == $past(ext_trig_i))
    else $error("gated output not following gate");
  a_burst_stop: assert property (cbus && $fell(wave_o.active) |-> ##[0:1] !wave_o.run)
    else $error("carrier left running after burst");
endmodule
bind bmc_top bmc_monitor mon_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .prdata_o(prdata_o), .ext_trig_i(ext_trig_i), .backplane_trigger_line_i(backplane_trigger_line_i),
  .wave_o(wave_o), .other_mod_en_o(other_mod_en_o));

// ===== verif/burst_modulation_control_bench.sv
// self-checking bench for the burst modulation controller
`timescale 1ns/1ps
module burst_modulation_control_bench;
  logic              clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic              pready_o;
  logic              pslverr_o;
  logic [31:0]       prdata_o;
  logic              gate = 1'b0;
  logic              use_bkp = 1'b0;
  logic              ext_trig;
  logic              bkp_trig;
  bmc_pkg::bmc_out_t wave_o;
  logic [2:0]        other_mod_en_o;
  logic [31:0]       q;
  logic              err;
  int                n;
  int                miscompares = 0;
  int                total_checks = 0;
  // 20 MHz system clock
  always #25 clk_i = ~clk_i;
  bmc_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
    .ext_trig_i(ext_trig), .backplane_trigger_line_i(bkp_trig), .wave_o(wave_o),
    .other_mod_en_o(other_mod_en_o));
  bmc_gate_src gate_u (.clk_i(clk_i), .level_i(gate), .use_bkp_i(use_bkp), .ext_trig_o(ext_trig),
    .bkp_trig_o(bkp_trig));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // one apb transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    q = prdata_o;
    err = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    check({31'h0, pready_o}, 32'h1);
  endtask
  task automatic wrchk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
    apb(1'b1, a, d);
    apb(1'b0, a, 32'h0);
    check(q & m, e);
  endtask
  // clocks with a counted burst in progress over a window
  task automatic cnt_active(input int span, output int c);
    c = 0;
    repeat (span) begin
      @(posedge clk_i);
      if (wave_o.active === 1'b1) c++;
    end
  endtask
  task automatic t_reset_regs();
    apb(1'b0, bmc_pkg::ADDR_RATE, 32'h0);
    check(q, {6'h00, bmc_pkg::RATE_RST});
    apb(1'b0, bmc_pkg::ADDR_CYCLES, 32'h0);
    check(q, 32'h0000_0001);
    apb(1'b0, bmc_pkg::ADDR_PHASE, 32'h0);
    check(q, 32'h0000_0000);
    apb(1'b0, bmc_pkg::ADDR_CTRL, 32'h0);
    check(q[1:0], 32'h0);
    apb(1'b0, bmc_pkg::ADDR_CONFIG, 32'h0);
    check(q, {3'b000, bmc_pkg::FREQ_RST});
    apb(1'b0, 8'h2C, 32'h0);
    check({err, q[30:0]}, 32'h8000_0000);
    check({wave_o.ampl, wave_o.offs}, {bmc_pkg::AMPL_RST, 16'h0000});
    apb(1'b1, 8'h02, 32'h0000_FFFF);
    check(err, 1'b1);
  endtask
  task automatic t_limits();
    wrchk(bmc_pkg::ADDR_CYCLES, 32'h0, 32'h1, 32'hFFFF_FFFF);
    wrchk(bmc_pkg::ADDR_CYCLES, 32'h0000_EA60, {16'h0, bmc_pkg::CYC_MAX}, 32'hFFFF_FFFF);
    wrchk(bmc_pkg::ADDR_CYCLES, 32'h8000_0000, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    wrchk(bmc_pkg::ADDR_PHASE, 32'h0006_1A80, {12'h0, bmc_pkg::PH_MAX}, 32'h000F_FFFF);
    wrchk(bmc_pkg::ADDR_PHASE, 32'hFFF9_E580, {12'h0, bmc_pkg::PH_MIN}, 32'h000F_FFFF);
    wrchk(bmc_pkg::ADDR_RATE, 32'h1, {6'h0, bmc_pkg::RATE_MIN}, 32'hFFFF_FFFF);
    wrchk(bmc_pkg::ADDR_RATE, 32'h0300_0000, {6'h0, bmc_pkg::RATE_MAX}, 32'hFFFF_FFFF);
  endtask
  task automatic t_clamp();
    wrchk(bmc_pkg::ADDR_CYCLES, 32'h2, 32'h2, 32'hFFFF_FFFF);
    apb(1'b1, bmc_pkg::ADDR_CTRL, 32'h0000_0005);
    wrchk(bmc_pkg::ADDR_FREQ, 32'h11E1_A300, 32'h0BEB_C200, 32'hFFFF_FFFF);
    apb(1'b0, bmc_pkg::ADDR_STATUS, 32'h0);
    check({q[31:16], 15'h0, q[0]}, {bmc_pkg::ERR_CONFLICT, 16'h0001});
    wrchk(bmc_pkg::ADDR_STATUS, 32'h1, 32'h0, 32'h1);
    wrchk(bmc_pkg::ADDR_CYCLES, 32'h64, 32'h64, 32'hFFFF_FFFF);
    wrchk(bmc_pkg::ADDR_FREQ, 32'h1, 32'h14, 32'hFFFF_FFFF);
    wrchk(bmc_pkg::ADDR_STATUS, 32'h0, 32'h1, 32'h1);
    apb(1'b1, bmc_pkg::ADDR_CTRL, 32'h0000_0010);
    apb(1'b1, bmc_pkg::ADDR_FREQ, 32'h1EFE_9200);
    wrchk(bmc_pkg::ADDR_DUTY, 32'h46, 32'h3C, 32'h7F);
    apb(1'b1, bmc_pkg::ADDR_FREQ, 32'h05F5_E100);
    wrchk(bmc_pkg::ADDR_DUTY, 32'h0A, 32'h14, 32'h7F);
    check(32'(wave_o.duty), 32'h14);
  endtask
  task automatic t_mod();
    apb(1'b1, bmc_pkg::ADDR_CTRL, 32'h0000_0280);
    cyc(2);
    check(other_mod_en_o, 3'b101);
    apb(1'b1, bmc_pkg::ADDR_CTRL, 32'h0000_0285);
    cyc(3);
    check(other_mod_en_o, 3'b000);
    wrchk(bmc_pkg::ADDR_CTRL, 32'h0000_0005, 32'h1, 32'h1);
  endtask
  // three cycles of 1 MHz carrier last sixty clocks, give or take the phase step rounding
  task automatic t_counted();
    wrchk(bmc_pkg::ADDR_CYCLES, 32'h3, 32'h3, 32'hFFFF_FFFF);
    cyc(10);
    check(wave_o.run, 1'b0);
    apb(1'b1, bmc_pkg::ADDR_TRIG, 32'h1);
    cnt_active(100, n);
    check(n >= 58 && n <= 62, 1'b1);
    check(wave_o.run, 1'b0);
    cnt_active(900, n);
    check(n, 32'h0);
    apb(1'b1, bmc_pkg::ADDR_CTRL, 32'h0000_0001);
    cnt_active(1200, n);
    check(n >= 100 && n <= 240, 1'b1);
    apb(1'b1, bmc_pkg::ADDR_CYCLES, 32'h32);
    cyc(1200);
    cnt_active(1000, n);
    check(n >= 950, 1'b1);
    wrchk(bmc_pkg::ADDR_RATE, {6'h0, bmc_pkg::RATE_MAX}, {6'h0, bmc_pkg::RATE_MAX}, 32'hFFFF_FFFF);
    apb(1'b0, bmc_pkg::ADDR_RATE, 32'h0);
    check(q, {6'h0, bmc_pkg::RATE_MAX});
  endtask
  task automatic t_gated();
    for (int s = 0; s < 2; s++) begin
      use_bkp <= s[0];
      apb(1'b1, bmc_pkg::ADDR_CTRL, s[0] ? 32'h0000_000F : 32'h0000_000B);
      gate <= 1'b1;
      cyc(4);
      check(wave_o.run, 1'b1);
      gate <= 1'b0;
      cyc(4);
      check({wave_o.run, wave_o.active}, 2'b00);
    end
  endtask
  task automatic t_infinite();
    apb(1'b1, bmc_pkg::ADDR_CTRL, 32'h0000_0005);
    apb(1'b1, bmc_pkg::ADDR_CYCLES, 32'h8000_0000);
    apb(1'b1, bmc_pkg::ADDR_TRIG, 32'h1);
    cyc(300);
    check({wave_o.run, wave_o.active}, 2'b11);
  endtask
  task automatic complete_run();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence after four clocks of reset
  initial begin
    cyc(4);
    nrst_i <= 1'b1;
    t_reset_regs();
    t_limits();
    t_clamp();
    t_mod();
    t_counted();
    t_gated();
    t_infinite();
    complete_run();
  end
  // watchdog, well past the few thousand clocks the sequence needs
  initial begin
    #1500000;
    miscompares++;
    complete_run();
  end
endmodule
